// file: ifa_dec_if.sv
// Address-to-region link between the top and the region decoder
`timescale 1ns/1ps
interface ifa_dec_if;
	import ifa_pkg::*;
	logic [19:0] addr;
	ifa_rgn_e rgn;
	modport dec (input addr, output rgn);
	modport user (output addr, input rgn);
endinterface

// file: ifa_decode.sv
// Region decoder for the 1-Mbyte address space
`timescale 1ns/1ps
module ifa_decode
	import ifa_pkg::*;
#(
	parameter int ROM_BYTES = IFA_ROM_BYTES_DEF,
	parameter int RAM_BYTES = IFA_RAM_BYTES_DEF
)
(
	ifa_dec_if.dec bus
);
	localparam int ROM_LO_I = 65536 - ROM_BYTES;
	localparam int RAM_HI_I = 1024 + RAM_BYTES - 1;
	localparam logic [19:0] ROM_LO = ROM_LO_I[19:0];
	localparam logic [19:0] RAM_HI = RAM_HI_I[19:0];

	function automatic ifa_rgn_e ifa_region(input logic [19:0] a);
		ifa_rgn_e r;
		r = IFA_RG_NONE;
		if (a >= IFA_SFR_LO && a <= IFA_SFR_HI)
			r = IFA_RG_SFR;
		else if (a >= IFA_VEC_LO && a <= IFA_ROM_TOP)
			r = IFA_RG_VEC;
		else if (a >= ROM_LO && a <= IFA_ROM_TOP)
			r = IFA_RG_ROM;
		else if (a >= IFA_RAM_BASE && a <= RAM_HI)
			r = IFA_RG_RAM;
		else
			r = IFA_RG_NONE;
		return r;
	endfunction

	always_comb
	begin
		bus.rgn = ifa_region(bus.addr);
	end
endmodule

// file: ifa_irq_src.sv
// Interrupt request source that holds each request until it is acknowledged
`timescale 1ns/1ps
module ifa_irq_src
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [2:0] lvl,
	input wire logic [5:0] vec,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [2:0] irq_level,
	output logic [5:0] irq_vector
);
	logic busy_q;
	logic [8:0] req_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			busy_q <= 1'b0;
		else if (go)
			busy_q <= 1'b1;
		else if (irq_ack)
			busy_q <= 1'b0;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			req_q <= 9'h0AA;
		else if (go)
			req_q <= {lvl, vec};
	// Idle lines show the inverse of the last request
	assign irq_req = busy_q;
	assign {irq_level, irq_vector} = busy_q ? req_q : ~req_q;
endmodule

// file: ifa_pkg.sv
// Constants, address map and region type for the interrupt flags and address map block
package ifa_pkg;
	localparam int IFA_ADDR_W = 20;
	localparam int IFA_IPL_W = 3;
	localparam int IFA_VEC_W = 6;
	localparam int IFA_SP_W = 16;
	localparam int IFA_PADDR_W = 12;

	localparam logic [19:0] IFA_SPACE_LO = 20'h00000;
	localparam logic [19:0] IFA_SPACE_HI = 20'hFFFFF;
	localparam logic [19:0] IFA_SFR_LO = 20'h00000;
	localparam logic [19:0] IFA_SFR_HI = 20'h002FF;
	localparam logic [19:0] IFA_RAM_BASE = 20'h00400;
	localparam logic [19:0] IFA_ROM_TOP = 20'h0FFFF;
	localparam logic [19:0] IFA_VEC_LO = 20'h0FFDC;
	localparam int IFA_ROM_BYTES_DEF = 49152;
	localparam int IFA_RAM_BYTES_DEF = 2048;

	localparam logic [11:0] IFA_FLAGS_OFS = 12'h000;
	localparam logic [11:0] IFA_HSP_OFS = 12'h004;
	localparam logic [11:0] IFA_USP_OFS = 12'h008;
	localparam logic [11:0] IFA_STATUS_OFS = 12'h00C;

	localparam int IFA_FLAG_I_BIT = 0;
	localparam int IFA_FLAG_U_BIT = 1;
	localparam int IFA_IPL_LSB = 2;
	localparam int IFA_RSV_BIT = 7;
	localparam int IFA_ST_HW_BIT = 6;
	localparam int IFA_ST_SPRAM_BIT = 7;

	localparam logic IFA_FLAG_I_RST = 1'b0;
	localparam logic IFA_FLAG_U_RST = 1'b0;
	localparam logic [2:0] IFA_IPL_RST = 3'h0;
	localparam logic [15:0] IFA_SP_RST = 16'h0000;
	localparam logic [5:0] IFA_TRAP_U_MAX = 6'h1F;

	typedef enum logic [2:0] {IFA_RG_NONE, IFA_RG_SFR, IFA_RG_RAM, IFA_RG_ROM, IFA_RG_VEC} ifa_rgn_e;
endpackage

// file: ifa_top.sv
// Interrupt acceptance flags, stack select and address decode with an APB register port
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
//
// Contract
// - Global mask flag at 0 refuses maskable requests; at 1 they may pass.
// - Any acknowledged interrupt clears the global mask flag to 0.
// - Stack select 0 picks handler stack pointer, 1 picks user stack pointer.
// - Stack select clears on hardware acknowledge or trap numbers 0 to 31.
// - Processor priority level is a 3-bit threshold, levels 0 to 7.
// - A request is taken only if its priority exceeds the current level.
// - Reserved flag bit: software writes 0; reads are undefined, may vary.
// - Decoder spans 1 Mbyte, addresses 00000h to FFFFFh.
// - ROM region ends at 0FFFFh and extends downward by ROM size.
// - 0FFDCh to 0FFFFh is the fixed vector table.
// - RAM region starts at 00400h and extends upward by RAM size.
// - RAM holds data and the stack for calls and interrupt context.
// - Peripheral register region is 00000h to 002FFh.
module ifa_top
	import ifa_pkg::*;
#(
	parameter int ROM_BYTES = IFA_ROM_BYTES_DEF,
	parameter int RAM_BYTES = IFA_RAM_BYTES_DEF
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic irq_req,
	input wire logic [2:0] irq_level,
	input wire logic [5:0] irq_vector,
	input wire logic sw_trap,
	input wire logic [5:0] sw_trap_num,
	output logic irq_ack,
	output logic trap_ack,
	output logic [5:0] ack_vector,
	output logic stack_sel,
	output logic [15:0] stack_ptr,
	input wire logic cpu_valid,
	input wire logic [19:0] cpu_addr,
	output logic sel_sfr,
	output logic sel_ram,
	output logic sel_rom,
	output logic sel_vec,
	output logic sel_none
);
	if (ROM_BYTES < 64 || ROM_BYTES > 65536 - 1024 - RAM_BYTES)
		$error("ROM_BYTES out of range");
	if (RAM_BYTES < 16 || RAM_BYTES > 64512)
		$error("RAM_BYTES out of range");

	typedef struct packed {
		logic flag_i;
		logic flag_u;
		logic [2:0] processor_priority_level;
		logic [15:0] hsp;
		logic [15:0] user_stack_pointer;
		logic [5:0] last_vec;
		logic last_hw;
		logic junk;
		logic irq_ack;
		logic trap_ack;
		logic [5:0] ack_vec;
		logic [15:0] sp;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic special_function_registers;
		logic ram;
		logic rom;
		logic vec;
		logic none;
	} ifa_state_s;

	ifa_state_s st_q;
	ifa_state_s st_d;

	ifa_dec_if cpu_dec ();
	ifa_dec_if sp_dec ();

	ifa_decode #(.ROM_BYTES(ROM_BYTES), .RAM_BYTES(RAM_BYTES)) u_cpu_dec (.bus(cpu_dec.dec));
	ifa_decode #(.ROM_BYTES(ROM_BYTES), .RAM_BYTES(RAM_BYTES)) u_sp_dec (.bus(sp_dec.dec));

	assign cpu_dec.addr = cpu_addr;
	assign sp_dec.addr = {4'h0, st_q.sp};

	function automatic logic [15:0] ifa_merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction

	logic setup;
	logic wr_take;
	logic hw_take;
	logic sp_in_ram;

	always_comb
	begin
		setup = psel && !penable;
		wr_take = psel && penable && st_q.pready && pwrite;
		hw_take = irq_req && st_q.flag_i && (irq_level > st_q.processor_priority_level)
			&& !st_q.irq_ack && !st_q.trap_ack && !sw_trap;
		sp_in_ram = (sp_dec.rgn == IFA_RG_RAM);
		st_d = st_q;
		st_d.junk = !st_q.junk;
		st_d.irq_ack = 1'b0;
		st_d.trap_ack = 1'b0;
		st_d.pready = 1'b0;
		st_d.pslverr = 1'b0;
		// Register writes; an acknowledge in the same cycle overrides I, and U except for a trap above 1Fh
		if (wr_take && paddr == IFA_FLAGS_OFS && pstrb[0])
		begin
			st_d.flag_i = pwdata[IFA_FLAG_I_BIT];
			st_d.flag_u = pwdata[IFA_FLAG_U_BIT];
			st_d.processor_priority_level = pwdata[IFA_IPL_LSB +: IFA_IPL_W];
		end
		else if (wr_take && paddr == IFA_HSP_OFS)
			st_d.hsp = ifa_merge16(st_q.hsp, pwdata, pstrb);
		else if (wr_take && paddr == IFA_USP_OFS)
			st_d.user_stack_pointer = ifa_merge16(st_q.user_stack_pointer, pwdata, pstrb);
		// Traps are instructions and go before a pending hardware request
		if (sw_trap && !st_q.trap_ack)
		begin
			st_d.trap_ack = 1'b1;
			st_d.ack_vec = sw_trap_num;
			st_d.last_vec = sw_trap_num;
			st_d.last_hw = 1'b0;
			st_d.flag_i = 1'b0;
			if (sw_trap_num <= IFA_TRAP_U_MAX)
				st_d.flag_u = 1'b0;
		end
		else if (hw_take)
		begin
			st_d.irq_ack = 1'b1;
			st_d.ack_vec = irq_vector;
			st_d.last_vec = irq_vector;
			st_d.last_hw = 1'b1;
			st_d.flag_i = 1'b0;
			st_d.flag_u = 1'b0;
		end
		st_d.sp = st_d.flag_u ? st_d.user_stack_pointer : st_d.hsp;
		// Read data is captured in the setup cycle; answer comes in the first access cycle
		if (setup)
		begin
			st_d.pready = 1'b1;
			st_d.prdata = 32'h0000_0000;
			if (paddr == IFA_FLAGS_OFS)
			begin
				st_d.prdata[IFA_FLAG_I_BIT] = st_q.flag_i;
				st_d.prdata[IFA_FLAG_U_BIT] = st_q.flag_u;
				st_d.prdata[IFA_IPL_LSB +: IFA_IPL_W] = st_q.processor_priority_level;
				st_d.prdata[IFA_RSV_BIT] = st_q.junk;
			end
			else if (paddr == IFA_HSP_OFS)
				st_d.prdata[15:0] = st_q.hsp;
			else if (paddr == IFA_USP_OFS)
				st_d.prdata[15:0] = st_q.user_stack_pointer;
			else if (paddr == IFA_STATUS_OFS && !pwrite)
			begin
				st_d.prdata[5:0] = st_q.last_vec;
				st_d.prdata[IFA_ST_HW_BIT] = st_q.last_hw;
				st_d.prdata[IFA_ST_SPRAM_BIT] = sp_in_ram;
			end
			else
				st_d.pslverr = 1'b1;
		end
		else if (psel && penable && st_q.pready)
			st_d.prdata = 32'h0000_0000;
		st_d.special_function_registers = cpu_valid && cpu_dec.rgn == IFA_RG_SFR;
		st_d.ram = cpu_valid && cpu_dec.rgn == IFA_RG_RAM;
		st_d.rom = cpu_valid && cpu_dec.rgn == IFA_RG_ROM;
		st_d.vec = cpu_valid && cpu_dec.rgn == IFA_RG_VEC;
		st_d.none = cpu_valid && cpu_dec.rgn == IFA_RG_NONE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= '0;
			st_q.flag_i <= IFA_FLAG_I_RST;
			st_q.flag_u <= IFA_FLAG_U_RST;
			st_q.processor_priority_level <= IFA_IPL_RST;
			st_q.hsp <= IFA_SP_RST;
			st_q.user_stack_pointer <= IFA_SP_RST;
			st_q.sp <= IFA_SP_RST;
		end
		else
			st_q <= st_d;
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign irq_ack = st_q.irq_ack;
	assign trap_ack = st_q.trap_ack;
	assign ack_vector = st_q.ack_vec;
	assign stack_sel = st_q.flag_u;
	assign stack_ptr = st_q.sp;
	assign sel_sfr = st_q.special_function_registers;
	assign sel_ram = st_q.ram;
	assign sel_rom = st_q.rom;
	assign sel_vec = st_q.vec;
	assign sel_none = st_q.none;

	localparam int ROM_LO_A = 65536 - ROM_BYTES;
	localparam int RAM_HI_A = 1024 + RAM_BYTES - 1;

	AST_MASK_GATES: assert property (@(posedge pclk) disable iff (!presetn)
		irq_ack |-> $past(st_q.flag_i) && $past(irq_req))
		else $error("hardware acknowledge while mask flag was 0");
	AST_PRIO_ABOVE: assert property (@(posedge pclk) disable iff (!presetn)
		irq_ack |-> $past(irq_level) > $past(st_q.processor_priority_level))
		else $error("acknowledged request not above priority level");
	AST_ACK_CLEARS_I: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_ack || trap_ack) |-> !st_q.flag_i)
		else $error("mask flag not cleared on acknowledge");
	AST_HW_CLEARS_U: assert property (@(posedge pclk) disable iff (!presetn)
		irq_ack |-> !stack_sel)
		else $error("stack select not cleared on hardware acknowledge");
	AST_TRAP_U: assert property (@(posedge pclk) disable iff (!presetn)
		trap_ack && $past(sw_trap_num) <= 6'h1F |-> !stack_sel && ack_vector == $past(sw_trap_num))
		else $error("low trap did not clear stack select");
	AST_SP_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stack_sel) && !$past(wr_take && paddr == IFA_USP_OFS) |-> stack_ptr == $past(st_q.user_stack_pointer))
		else $error("stack pointer not user pointer after select set");
	AST_SFR_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		$past(cpu_valid) && $past(cpu_addr) <= 20'h002FF |-> sel_sfr && !sel_ram && !sel_none)
		else $error("peripheral region not selected");
	AST_VEC_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		$past(cpu_valid) && $past(cpu_addr) >= 20'h0FFDC && $past(cpu_addr) <= 20'h0FFFF |-> sel_vec)
		else $error("vector table not selected");
	AST_RAM_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		sel_ram |-> $past(cpu_addr) >= 20'h00400 && $past(cpu_addr) <= RAM_HI_A[19:0])
		else $error("RAM selected outside its range");
	AST_ROM_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		sel_rom |-> $past(cpu_addr) >= ROM_LO_A[19:0] && $past(cpu_addr) < 20'h0FFDC)
		else $error("ROM selected outside its range");
	AST_NONE_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		$past(cpu_valid) && $past(cpu_addr) > 20'h0FFFF |-> sel_none && !sel_rom && !sel_vec)
		else $error("address above ROM selected a target");
	AST_APB_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("APB answer not exactly one access cycle");
endmodule

// file: tb.sv
// Self-checking testbench for the interrupt flags and address map block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb
	import ifa_pkg::*;
;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, sw_trap = 0;
	logic cpu_valid = 0, pready, pslverr, irq_req, irq_ack, trap_ack, stack_sel;
	logic sel_sfr, sel_ram, sel_rom, sel_vec, sel_none;
	logic [2:0] lvl = 3'h0, irq_level;
	logic [5:0] vec = 6'h00, sw_trap_num = 6'h00, irq_vector, ack_vector;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h3D, usp_v, m;
	logic [15:0] stack_ptr;
	logic [19:0] cpu_addr = 20'h0, a;
	logic [32:0] e;
	logic [4:0] s;
	logic [32:0] q_exp[$];
	logic [31:0] q_msk[$];
	logic [4:0] q_sel[$];
	logic [19:0] al[14] = '{20'h00000, 20'h002FF, 20'h00300, 20'h003FF, 20'h00400, 20'h00BFF,
		20'h00C00, 20'h03FFF, 20'h04000, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF, 20'h10000, 20'hFFFFF};
	logic [5:0] tn[4] = '{6'h03, 6'h1F, 6'h20, 6'h28};
	int err_count = 0, cmp_count = 0, cyc = 0;

	ifa_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level),
		.irq_vector(irq_vector), .sw_trap(sw_trap), .sw_trap_num(sw_trap_num),
		.irq_ack(irq_ack), .trap_ack(trap_ack), .ack_vector(ack_vector),
		.stack_sel(stack_sel), .stack_ptr(stack_ptr), .cpu_valid(cpu_valid),
		.cpu_addr(cpu_addr), .sel_sfr(sel_sfr), .sel_ram(sel_ram), .sel_rom(sel_rom),
		.sel_vec(sel_vec), .sel_none(sel_none));
	ifa_irq_src src (.pclk(pclk), .presetn(presetn), .go(go), .lvl(lvl), .vec(vec),
		.irq_ack(irq_ack), .irq_req(irq_req), .irq_level(irq_level), .irq_vector(irq_vector));

	always #2 pclk = ~pclk;

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			err_count++;
			wrap_up();
		end
		if (pready === 1'b1)
		begin
			e = q_exp.pop_front();
			m = q_msk.pop_front();
			`CHK("apb", e & {1'b1, m}, {pslverr, prdata} & {1'b1, m})
		end
		if ((sel_sfr | sel_ram | sel_rom | sel_vec | sel_none) === 1'b1)
		begin
			s = q_sel.pop_front();
			`CHK("sel", s, {sel_sfr, sel_ram, sel_rom, sel_vec, sel_none})
		end
	end

	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// One-hot order: sfr, ram, rom, vec, none
	function logic [4:0] exp_sel(input logic [19:0] x);
		if (x <= IFA_SFR_HI)
			return 5'h10;
		if (x >= IFA_RAM_BASE && x < IFA_RAM_BASE + IFA_RAM_BYTES_DEF)
			return 5'h08;
		if (x >= IFA_VEC_LO && x <= IFA_ROM_TOP)
			return 5'h02;
		if (x > IFA_ROM_TOP - IFA_ROM_BYTES_DEF && x <= IFA_ROM_TOP)
			return 5'h04;
		return 5'h01;
	endfunction

	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		input logic [32:0] ex, input logic [31:0] mk);
		int n;
		n = 0;
		q_exp.push_back(ex);
		q_msk.push_back(mk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, 33'h0, 32'h0);
	endtask

	task rd(input logic [11:0] ad, input logic [31:0] d, input logic [31:0] mk);
		apb(1'b0, ad, 32'h0, {1'b0, d}, mk);
	endtask

	task raise(input logic [2:0] l, input logic [5:0] v);
		go <= 1;
		lvl <= l;
		vec <= v;
		@(posedge pclk);
		go <= 0;
	endtask

	task no_ack(input int n);
		repeat (n)
		begin
			@(posedge pclk);
			`CHK("noack", 1'b0, irq_ack | trap_ack)
		end
	endtask

	task get_ack(input logic hw, input logic sel);
		int n;
		n = 0;
		do @(posedge pclk); while (!(irq_ack === 1'b1 || trap_ack === 1'b1) && n++ < 20);
		`CHK("irq_ack", hw, irq_ack)
		`CHK("trap_ack", ~hw, trap_ack)
		`CHK("stack_sel", sel, stack_sel)
	endtask

	task wrap_up;
		if (q_exp.size() != 0 || q_sel.size() != 0)
			err_count++;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(IFA_FLAGS_OFS, 32'h0, 32'h7F);
		seed = xs(seed);
		usp_v = seed & 32'hFFFF;
		wr(IFA_HSP_OFS, 32'h0500);
		wr(IFA_USP_OFS, usp_v);
		rd(IFA_USP_OFS, usp_v, ALL);
		apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0}, ALL);
		apb(1'b1, IFA_STATUS_OFS, 32'h0, {1'b1, 32'h0}, 32'h0);
		$display("registers done");
		raise(3'h5, 6'h09);
		no_ack(12);
		wr(IFA_FLAGS_OFS, 32'h0A);
		`CHK("usp", usp_v[15:0], stack_ptr)
		wr(IFA_FLAGS_OFS, 32'h0B);
		get_ack(1'b1, 1'b0);
		`CHK("hsp", 16'h0500, stack_ptr)
		`CHK("vector", 6'h09, ack_vector)
		rd(IFA_FLAGS_OFS, 32'h08, 32'h7F);
		rd(IFA_STATUS_OFS, 32'hC9, ALL);
		$display("mask and stack done");
		wr(IFA_FLAGS_OFS, 32'h15);
		raise(3'h5, 6'h21);
		no_ack(10);
		wr(IFA_FLAGS_OFS, 32'h11);
		get_ack(1'b1, 1'b0);
		wr(IFA_FLAGS_OFS, 32'h1F);
		rd(IFA_FLAGS_OFS, 32'h1F, 32'h7F);
		$display("priority done");
		for (int i = 0; i < 4; i++)
		begin
			wr(IFA_FLAGS_OFS, 32'h03);
			sw_trap <= 1;
			sw_trap_num <= tn[i];
			@(posedge pclk);
			sw_trap <= 0;
			get_ack(1'b0, tn[i] > IFA_TRAP_U_MAX);
			rd(IFA_FLAGS_OFS, {30'h0, tn[i] > IFA_TRAP_U_MAX, 1'b0}, 32'h7F);
		end
		$display("traps done");
		for (int i = 0; i < 34; i++)
		begin
			a = (i < 14) ? al[i] : seed[19:0];
			seed = xs(seed);
			q_sel.push_back(exp_sel(a));
			cpu_valid <= 1;
			cpu_addr <= a;
			@(posedge pclk);
		end
		cpu_valid <= 0;
		repeat (3) @(posedge pclk);
		$display("decode done");
		wrap_up();
	end
endmodule
